// ### hw/pmt_pkg.sv
// package of shared types and constants for the plc mode timer
`default_nettype none
package pmt_pkg;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int unsigned NUM_TIMERS = 512;
  localparam int unsigned IDX_W      = 9;
  localparam int unsigned TIME_W     = 32;
  localparam int unsigned TRIG_N     = 4;

  // ****************************************************************
  // trigger positions inside the packed trigger vector
  // ****************************************************************
  localparam int unsigned TRIG_PULSE = 0;
  localparam int unsigned TRIG_ON    = 1;
  localparam int unsigned TRIG_OFF   = 2;
  localparam int unsigned TRIG_LIMIT = 3;

  // ****************************************************************
  // timing: clock period and the millisecond tick
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [TIME_W-1:0] ELAPSED_RST = 32'h0000_0000;
  localparam logic [TIME_W-1:0] CONST_RST   = 32'h0000_0000;
  localparam logic [TRIG_N-1:0] TRIG_RST    = 4'h0;
  localparam logic              GATE_RST    = 1'h1;
  localparam logic              CLEAR_RST   = 1'h0;

  // per-timer state, gray coded in listed order; moves out of idle into on, off or limit flip two bits
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_PULSE_RUN = 3'h1,
    ST_ON_RUN    = 3'h3,
    ST_ON_DONE   = 3'h2,
    ST_OFF_ARMED = 3'h6,
    ST_OFF_RUN   = 3'h7,
    ST_LIMIT_RUN = 3'h5
  } pmt_state_t;

  // input levels written for one timer in one cycle
  typedef struct packed {
    logic clear_input;
    logic count_gate;
    logic limit_trigger;
    logic off_delay_trigger;
    logic on_delay_trigger;
    logic pulse_trigger;
  } pmt_inputs_t;

  // result of a read of one timer
  typedef struct packed {
    logic              status;
    logic [TIME_W-1:0] elapsed;
  } pmt_result_t;

endpackage : pmt_pkg
`default_nettype wire

// ### hw/pmt_timer_bank.sv
// bank of plc mode timers with a write port for input levels and a read port
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_bank #(
  parameter int unsigned NUM_TIMERS  = pmt_pkg::NUM_TIMERS,
  parameter int unsigned IDX_W       = pmt_pkg::IDX_W,
  parameter int unsigned TICK_CYCLES = pmt_pkg::TICK_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         wr_valid,
  input  wire logic [IDX_W-1:0]             wr_index,
  input  wire pmt_pkg::pmt_inputs_t         wr_inputs,
  input  wire logic [pmt_pkg::TIME_W-1:0]   wr_constant,
  input  wire logic [IDX_W-1:0]             rd_index,
  output var  pmt_pkg::pmt_result_t         rd_result,
  output var  logic                         tick_ms
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (IDX_W < 1 || IDX_W > 30) begin : g_bad_index
    $error("IDX_W must lie between 1 and 30");
  end
  if (NUM_TIMERS < 1 || NUM_TIMERS > (1 << IDX_W)) begin : g_bad_count
    $error("NUM_TIMERS does not fit the index width");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end
  // the datapath assumes one 32-bit word per value and four trigger modes
  if (pmt_pkg::TIME_W != 32 || pmt_pkg::TRIG_N != 4) begin : g_bad_pkg
    $error("package widths do not match the datapath");
  end

  // short local names for the package widths
  localparam int unsigned TW = pmt_pkg::TIME_W;
  localparam int unsigned TN = pmt_pkg::TRIG_N;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // states in which the elapsed time may advance
  function automatic logic is_timing(input pmt_pkg::pmt_state_t st);
    is_timing = (st == pmt_pkg::ST_PULSE_RUN) || (st == pmt_pkg::ST_ON_RUN) ||
                (st == pmt_pkg::ST_OFF_RUN)   || (st == pmt_pkg::ST_LIMIT_RUN);
  endfunction : is_timing

  // one-bit status seen by a bit-level read
  function automatic logic status_of(input pmt_pkg::pmt_state_t st);
    status_of = (st == pmt_pkg::ST_PULSE_RUN) || (st == pmt_pkg::ST_ON_DONE) ||
                (st == pmt_pkg::ST_OFF_ARMED) || (st == pmt_pkg::ST_OFF_RUN) ||
                (st == pmt_pkg::ST_LIMIT_RUN);
  endfunction : status_of

  // bits that are high in the new levels and were low in the old ones
  function automatic logic [pmt_pkg::TRIG_N-1:0] edge_of(
    input logic [pmt_pkg::TRIG_N-1:0] old_lvl,
    input logic [pmt_pkg::TRIG_N-1:0] new_lvl
  );
    edge_of = new_lvl & ~old_lvl;
  endfunction : edge_of

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // free-running divider; one pulse per millisecond
  // runs even with every timer idle, so ticks keep a fixed phase
  always_comb begin
    if (tick_cnt_r >= TICK_LAST) begin
      tick_cnt_nxt = 32'h0000_0000;
      tick_nxt     = 1'h1;
    end else begin
      tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
      tick_nxt     = 1'h0;
    end
  end

  // divider registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign tick_ms = tick_r;

  // ****************************************************************
  // timer state arrays
  // ****************************************************************
  // all timers live in flip-flops so each can be read in any cycle;
  // a memory would cost less area but could not advance every timer at once
  pmt_pkg::pmt_state_t state_r      [NUM_TIMERS];
  pmt_pkg::pmt_state_t state_nxt    [NUM_TIMERS];
  logic [TW-1:0]       elapsed_r    [NUM_TIMERS];
  logic [TW-1:0]       elapsed_nxt  [NUM_TIMERS];
  logic [TW-1:0]       const_r      [NUM_TIMERS];
  logic [TW-1:0]       const_nxt    [NUM_TIMERS];
  logic [TN-1:0]       trig_prev_r  [NUM_TIMERS];
  logic [TN-1:0]       trig_prev_nxt[NUM_TIMERS];
  logic                clr_prev_r   [NUM_TIMERS];
  logic                clr_prev_nxt [NUM_TIMERS];
  logic                gate_r       [NUM_TIMERS];
  logic                gate_nxt     [NUM_TIMERS];

  // write-side trigger vector, pulse trigger in bit 0
  // one write per cycle stands in for a full set of pins per timer
  logic [TN-1:0] wr_trig;
  assign wr_trig = {wr_inputs.limit_trigger, wr_inputs.off_delay_trigger,
                    wr_inputs.on_delay_trigger, wr_inputs.pulse_trigger};

  // next values of every timer; edges only exist on the addressed timer
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      logic          hit;
      logic [TN-1:0] rise;
      logic [TN-1:0] fall;
      logic          clr_rise;
      logic          done;
      hit      = wr_valid && (wr_index == IDX_W'(i));
      rise     = hit ? edge_of(trig_prev_r[i], wr_trig) : '0;
      fall     = hit ? edge_of(wr_trig, trig_prev_r[i]) : '0;
      clr_rise = hit && wr_inputs.clear_input && !clr_prev_r[i];
      done     = elapsed_r[i] >= const_r[i];

      state_nxt[i]     = state_r[i];
      elapsed_nxt[i]   = elapsed_r[i];
      const_nxt[i]     = const_r[i];
      trig_prev_nxt[i] = hit ? wr_trig : trig_prev_r[i];
      clr_prev_nxt[i]  = hit ? wr_inputs.clear_input : clr_prev_r[i];
      gate_nxt[i]      = hit ? wr_inputs.count_gate : gate_r[i];

      if (clr_rise) begin
        // clear beats any trigger edge of the same write
        // trigger history drops to zero, so held triggers count as new rises
        state_nxt[i]     = pmt_pkg::ST_IDLE;
        elapsed_nxt[i]   = pmt_pkg::ELAPSED_RST;
        trig_prev_nxt[i] = pmt_pkg::TRIG_RST;
      end else begin
        case (state_r[i])
          pmt_pkg::ST_IDLE: begin
            // only a fresh rise restarts a finished timer
            if (rise != '0) begin
              const_nxt[i]   = wr_constant;
              elapsed_nxt[i] = pmt_pkg::ELAPSED_RST;
              gate_nxt[i]    = pmt_pkg::GATE_RST;
              if (rise[pmt_pkg::TRIG_PULSE]) begin
                state_nxt[i] = pmt_pkg::ST_PULSE_RUN;
              end else if (rise[pmt_pkg::TRIG_ON]) begin
                state_nxt[i] = pmt_pkg::ST_ON_RUN;
              end else if (rise[pmt_pkg::TRIG_OFF]) begin
                state_nxt[i] = pmt_pkg::ST_OFF_ARMED;
              end else begin
                state_nxt[i] = pmt_pkg::ST_LIMIT_RUN;
              end
            end
          end
          pmt_pkg::ST_PULSE_RUN: begin
            // trigger edges have no effect here
            if (done) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end
          end
          pmt_pkg::ST_ON_RUN: begin
            if (fall[pmt_pkg::TRIG_ON]) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end else if (done) begin
              state_nxt[i] = pmt_pkg::ST_ON_DONE;
            end
          end
          pmt_pkg::ST_ON_DONE: begin
            // status stays high until the on-delay trigger is released
            if (fall[pmt_pkg::TRIG_ON]) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end
          end
          pmt_pkg::ST_OFF_ARMED: begin
            if (fall[pmt_pkg::TRIG_OFF]) begin
              state_nxt[i]   = pmt_pkg::ST_OFF_RUN;
              elapsed_nxt[i] = pmt_pkg::ELAPSED_RST;
            end
          end
          pmt_pkg::ST_OFF_RUN: begin
            if (rise[pmt_pkg::TRIG_OFF]) begin
              // re-armed: status stays high, count from zero on next fall
              state_nxt[i]   = pmt_pkg::ST_OFF_ARMED;
              elapsed_nxt[i] = pmt_pkg::ELAPSED_RST;
              const_nxt[i]   = wr_constant;
              gate_nxt[i]    = pmt_pkg::GATE_RST;
            end else if (done) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end
          end
          pmt_pkg::ST_LIMIT_RUN: begin
            if (fall[pmt_pkg::TRIG_LIMIT]) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end else if (done) begin
              state_nxt[i] = pmt_pkg::ST_IDLE;
            end
          end
          default: begin
            state_nxt[i] = pmt_pkg::ST_IDLE;
          end
        endcase

        // advance only while staying in a timing state; gate low freezes
        // stopping at the constant keeps the held time exact
        if ((state_nxt[i] == state_r[i]) && is_timing(state_r[i]) &&
            tick_r && gate_r[i] && !done) begin
          elapsed_nxt[i] = elapsed_r[i] + 32'h0000_0001;
        end
      end
    end
  end

  // register every timer
  // every timer starts idle with its gate open and no edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        state_r[i]     <= pmt_pkg::ST_IDLE;
        elapsed_r[i]   <= pmt_pkg::ELAPSED_RST;
        const_r[i]     <= pmt_pkg::CONST_RST;
        trig_prev_r[i] <= pmt_pkg::TRIG_RST;
        clr_prev_r[i]  <= pmt_pkg::CLEAR_RST;
        gate_r[i]      <= pmt_pkg::GATE_RST;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        state_r[i]     <= state_nxt[i];
        elapsed_r[i]   <= elapsed_nxt[i];
        const_r[i]     <= const_nxt[i];
        trig_prev_r[i] <= trig_prev_nxt[i];
        clr_prev_r[i]  <= clr_prev_nxt[i];
        gate_r[i]      <= gate_nxt[i];
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  pmt_pkg::pmt_result_t rd_r;
  pmt_pkg::pmt_result_t rd_nxt;

  // one cycle of latency; an index past the bank reads as zero
  // status and elapsed time travel together; the reader picks one
  always_comb begin
    rd_nxt = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (rd_index == IDX_W'(i)) begin
        rd_nxt.status  = status_of(state_r[i]);
        rd_nxt.elapsed = elapsed_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_result = rd_r;

endmodule : pmt_timer_bank
`default_nettype wire

// ### verification/pmt_bank_checker.sv
// assertions on the port timing of the plc mode timer bank
`timescale 1ns/1ps
`default_nettype none
module pmt_bank_checker #(
  parameter int unsigned NUM_TIMERS  = 4,
  parameter int unsigned IDX_W       = 9,
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 wr_valid,
  input wire logic [IDX_W-1:0]     wr_index,
  input wire pmt_pkg::pmt_inputs_t wr_inputs,
  input wire logic [31:0]          wr_constant,
  input wire logic [IDX_W-1:0]     rd_index,
  input wire pmt_pkg::pmt_result_t rd_result,
  input wire logic                 tick_ms
);
  // ****************
  // levels last written per timer, cycles since the last tick
  // ****************
  logic [5:0]  hist_r [2**IDX_W];
  logic [31:0] cnt_r;
  logic        seen_r;
  logic [5:0]  win;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic        hit;
  logic        hi_go;
  logic        on_go;
  logic        low_go;
  // lowest trigger wins, a clear rise beats every trigger
  assign win    = wr_inputs;
  assign rise   = win & ~hist_r[wr_index];
  assign fall   = ~win & hist_r[wr_index];
  assign hit    = wr_valid && wr_index == rd_index && 32'(wr_index) < NUM_TIMERS;
  assign hi_go  = !rise[5] && (rise[0] || (!rise[1] && (rise[2] || rise[3])));
  assign on_go  = !rise[5] && rise[1] && !rise[0];
  assign low_go = !rise[5] && rise[3:0] == 4'h0 && (fall[1] || fall[3]);
  // a clear rise wipes trigger history, so later ones become edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 32'h0;
      seen_r <= 1'b0;
      for (int i = 0; i < 2**IDX_W; i++) begin
        hist_r[i] <= 6'h00;
      end
    end else begin
      cnt_r  <= tick_ms ? 32'h1 : cnt_r + 32'h1;
      seen_r <= seen_r | tick_ms;
      if (wr_valid && 32'(wr_index) < NUM_TIMERS) begin
        hist_r[wr_index] <= rise[5] ? {win[5:4], 4'h0} : win;
      end
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tick_period: assert property (seen_r |-> tick_ms == (cnt_r == TICK_CYCLES))
    else $error("tick spacing wrong");
  a_read_range: assert property (32'(rd_index) >= NUM_TIMERS |=> rd_result == '0)
    else $error("out of range read not zero");
  a_clear_zero: assert property (hit && rise[5] ##1 $stable(rd_index) |=> rd_result == '0)
    else $error("clear did not zero timer");
  a_high_start: assert property (hit && hi_go ##1 $stable(rd_index)
    |=> rd_result.status && rd_result.elapsed == 32'h0) else $error("start not high");
  a_on_start: assert property (hit && on_go ##1 $stable(rd_index)
    |=> !rd_result.status && rd_result.elapsed == 32'h0) else $error("on start wrong");
  a_trig_fall: assert property (hit && low_go ##1 $stable(rd_index)
    |=> !rd_result.status) else $error("status high after fall");
  a_frozen_time: assert property ($past(rd_index) == $past(rd_index, 2) && !$past(hit, 2)
    && !$past(tick_ms, 2) |-> $stable(rd_result.elapsed)) else $error("time moved");
  a_step_one: assert property ($past(rd_index) == $past(rd_index, 2) && !$past(hit, 2)
    && $past(tick_ms, 2) |-> rd_result.elapsed - $past(rd_result.elapsed) <= 32'h1)
    else $error("time step too large");
endmodule : pmt_bank_checker
`default_nettype wire

// ### verification/pmt_ctrl_model.sv
// controller model that writes new input levels into one timer per call
`timescale 1ns/1ps
`default_nettype none
module pmt_ctrl_model (
  input  wire logic                 clk,
  output var  logic                 wr_valid,
  output var  logic [8:0]           wr_index,
  output var  pmt_pkg::pmt_inputs_t wr_inputs,
  output var  logic [31:0]          wr_constant
);
  initial begin
    wr_valid    = 1'b0;
    wr_index    = 9'h000;
    wr_inputs   = pmt_pkg::pmt_inputs_t'(6'h10);
    wr_constant = 32'h0;
  end
  // one-cycle strobe; fields scrambled after it so stale values never help
  task automatic put(input logic [8:0] i, input pmt_pkg::pmt_inputs_t v, input logic [31:0] c);
    @(negedge clk);
    wr_index    = i;
    wr_inputs   = v;
    wr_constant = c;
    wr_valid    = 1'b1;
    @(negedge clk);
    wr_valid    = 1'b0;
    wr_index    = ~i;
    wr_inputs   = ~v;
    wr_constant = ~c;
  endtask : put
endmodule : pmt_ctrl_model
`default_nettype wire

// ### verification/pmt_timer_bank_bench.sv
// self-checking bench for the plc mode timer bank
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_bank_bench;
  logic                 clk;
  logic                 rst_n;
  logic                 wr_valid;
  logic [8:0]           wr_index;
  logic [8:0]           rd_index;
  logic [31:0]          wr_constant;
  logic                 tick_ms;
  pmt_pkg::pmt_inputs_t wr_inputs;
  pmt_pkg::pmt_result_t rd_result;
  int                   n_fail = 0;
  int                   n_tests = 0;
  int                   cyc = 0;
  // a millisecond shrunk to eight clocks keeps the run short
  pmt_timer_bank #(.NUM_TIMERS(4), .TICK_CYCLES(8)) dut (.clk(clk), .rst_n(rst_n),
    .wr_valid(wr_valid), .wr_index(wr_index), .wr_inputs(wr_inputs),
    .wr_constant(wr_constant), .rd_index(rd_index), .rd_result(rd_result), .tick_ms(tick_ms));
  pmt_ctrl_model ctrl (.clk(clk), .wr_valid(wr_valid), .wr_index(wr_index),
    .wr_inputs(wr_inputs), .wr_constant(wr_constant));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: status %b, want %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: elapsed %0d, want %0d", $time, got, exp);
    end
  endtask : chk_word
  // trigger vector: bit 0 pulse, 1 on-delay, 2 off-delay, 3 limit
  task automatic w(input int i, input logic c, input logic g, input logic [3:0] t, input int k);
    rd_index = 9'(i);
    ctrl.put(9'(i), pmt_pkg::pmt_inputs_t'({c, g, t}), 32'(k));
  endtask : w
  // put returns at the negedge after the write edge; the next negedge shows
  // the state the write left, before a tick can move it; negative el: unchecked
  task automatic ex(input int st, input int el);
    @(negedge clk);
    chk_bit(rd_result.status, 1'(st));
    if (el >= 0) begin
      chk_word(rd_result.elapsed, 32'(el));
    end
  endtask : ex
  task automatic ms(input int n);
    repeat (n * 8) @(negedge clk);
  endtask : ms
  initial begin
    rst_n = 1'b0;
    rd_index = 9'h000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    ex(0, 0);
    // ****************
    // monostable, clear and gate on timer 0
    // ****************
    w(0, 0, 1, 4'h1, 3);
    ex(1, 0);
    w(0, 0, 1, 4'h0, 3);
    ex(1, -1);
    ms(5);
    ex(0, 3);
    w(0, 0, 1, 4'h1, 3);
    ex(1, 0);
    w(0, 1, 1, 4'h1, 3);
    ex(0, 0);
    w(0, 0, 1, 4'h0, 3);
    w(0, 0, 0, 4'h1, 3);
    ms(5);
    ex(0, 3);
    w(0, 0, 1, 4'h0, 4);
    w(0, 0, 1, 4'h1, 4);
    w(0, 0, 0, 4'h1, 4);
    ms(8);
    ex(1, -1);
    w(0, 0, 1, 4'h1, 4);
    ms(6);
    ex(0, 4);
    // ****************
    // on-delay, off-delay and limiting modes
    // ****************
    w(1, 0, 1, 4'h2, 2);
    ex(0, 0);
    ms(4);
    ex(1, 2);
    w(1, 0, 1, 4'h0, 2);
    ex(0, 2);
    w(1, 0, 1, 4'h2, 10);
    ms(2);
    w(1, 0, 1, 4'h0, 10);
    ex(0, -1);
    w(2, 0, 1, 4'h4, 3);
    ex(1, 0);
    ms(5);
    ex(1, 0);
    w(2, 0, 1, 4'h0, 3);
    ms(1);
    w(2, 0, 1, 4'h4, 3);
    ex(1, 0);
    w(2, 0, 1, 4'h0, 3);
    ms(5);
    ex(0, 3);
    w(3, 0, 1, 4'h8, 2);
    ex(1, 0);
    ms(4);
    ex(0, 2);
    w(3, 0, 1, 4'h0, 2);
    w(3, 0, 1, 4'h8, 20);
    ms(2);
    w(3, 0, 1, 4'h0, 20);
    ex(0, -1);
    // ****************
    // clear history, priority and range
    // ****************
    w(3, 0, 1, 4'h8, 20);
    w(3, 1, 1, 4'h8, 20);
    ex(0, 0);
    w(3, 0, 1, 4'h8, 2);
    ex(1, 0);
    w(1, 0, 1, 4'hF, 2);
    ex(1, 0);
    ms(4);
    ex(0, 2);
    w(1, 0, 1, 4'h0, 2);
    w(6, 0, 1, 4'h1, 5);
    ex(0, 0);
    complete_run();
  end
endmodule : pmt_timer_bank_bench
bind pmt_timer_bank pmt_bank_checker #(.NUM_TIMERS(NUM_TIMERS), .IDX_W(IDX_W),
  .TICK_CYCLES(TICK_CYCLES)) chk (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
  .wr_index(wr_index), .wr_inputs(wr_inputs), .wr_constant(wr_constant),
  .rd_index(rd_index), .rd_result(rd_result), .tick_ms(tick_ms));
`default_nettype wire
